/* src/lsf_pin_sync.sv */
// Three-stage synchroniser for the pins of the loop slave sequencer.
// Assumes asynchronous pins; a bit is taken once stages two and three agree.
`timescale 1ns/1ps
module lsf_pin_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // Pins and synchronised levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lsf_sync_t;

  lsf_sync_t r_reg;
  lsf_sync_t r_next;

  // Shift chain; output follows where stages two and three agree
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = pin_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.q  = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign pin_sync = r_reg.q;
endmodule

/* src/lsf_pkg.sv */
// Constants, timing counts and types for the loop slave frame sequencer.
// Assumes a 25 MHz ref_clk; the 4.096 MHz oscillator is modelled by a phase accumulator.
package lsf_pkg;
  // Clock rates
  localparam int REF_HZ  = 25_000_000;
  localparam int OSC_HZ  = 4_096_000;
  localparam int OSC_DIV = 32;         // Oscillator to data clock
  // Phase accumulator for half periods of the data clock (256 kHz)
  localparam int          HALF_HZ  = OSC_HZ / (OSC_DIV / 2);
  localparam logic [15:0] NCO_STEP = 16'(HALF_HZ / 1000);
  localparam logic [15:0] NCO_MOD  = 16'(REF_HZ / 1000);
  // Times in microseconds and their cycle counts
  localparam int SILENCE_US  = 250;
  localparam int FRAME_US    = 125;
  localparam int SILENCE_CYC = SILENCE_US * (REF_HZ / 1_000_000);
  localparam int FRAME_CYC   = FRAME_US * (REF_HZ / 1_000_000);
  // Frame layout in data clock periods
  localparam int VOICE_BITS     = 8;
  localparam int CLK_PERIODS    = 16;
  localparam int STROBE_PERIODS = 8;
  localparam int TX_LEAD_HALVES = 4;   // 256 kHz periods before return burst
  localparam logic [4:0] HALF_LAST  = 5'(2 * CLK_PERIODS - 1);
  localparam logic [4:0] STROBE_END = 5'(2 * STROBE_PERIODS);
  localparam logic [4:0] TX_LEAD    = 5'(TX_LEAD_HALVES);
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYC - 1);
  // Tone: 500 Hz square wave, frames per half cycle
  localparam int         TONE_HZ     = 500;
  localparam logic [3:0] TONE_FRAMES = 4'((1_000_000 / (2 * TONE_HZ)) / FRAME_US);
  // Tone PCM codes for the two levels
  localparam logic [7:0] TONE_MU_HI = 8'hA0;
  localparam logic [7:0] TONE_MU_LO = 8'h20;
  localparam logic [7:0] TONE_A_HI  = 8'hF5;
  localparam logic [7:0] TONE_A_LO  = 8'h75;
  // Pin synchroniser layout
  localparam int  PIN_W    = 7;
  localparam int  PIN_PWR  = 6;
  localparam int  PIN_LOOP = 5;
  localparam int  PIN_TONE = 4;
  localparam int  PIN_MU   = 3;
  localparam int  PIN_SA   = 2;
  localparam int  PIN_SB   = 1;
  localparam int  PIN_VIN  = 0;
  localparam logic [6:0] PIN_RST = 7'h60;
  // Frame sequencer states
  typedef enum logic [1:0] {
    LSF_IDLE = 2'b01,
    LSF_RUN  = 2'b10
  } lsf_seq_t;
endpackage

/* src/lsf_sequencer.sv */
// Frame sequencer of the remote end of a burst-mode loop transceiver.
// Assumes a demodulator on ref_clk giving burst_done with data; pins are asynchronous.
// Notes on behaviour
// - Loopback with power on returns demodulated voice instead of collected word.
// - Loopback with power on holds the data clock low, defeating codec port and tone.
// - Valid flag shows clean burst, updated as the output strobe rises.
// - Valid flag drops after 250 us without bursts, no strobe needed.
// - Signalling inputs sampled on strobe rise, or internal tick when free running.
// - Received signalling bits appear on outputs as the output strobe rises.
// - Powered down: receive side only, never transmits.
// - Powered up: one return burst per demodulated master burst.
// - Silent and powered: free 125 us tick, burst every second tick.
// - Power pin weakly driven high on burst, low after 250 us silence.
// - Tone request replaces demodulated voice with PCM 500 Hz square wave.
// - Tone request with no bursts runs clock and strobes internally.
// - Output strobe rises at burst end, high eight data clock periods.
// - Voice shifted out on first eight rising edges, floated otherwise.
// - Data clock 128 kHz, starts with the strobe at burst end.
// - Sixteen clock periods per frame, then low until next burst.
// - Return voice captured on eight falling edges after input strobe rises.
// - Tone coded mu-law when select is one, A-law when zero.
// - Data clock timing derives from the 4.096 MHz oscillator rate; silence and frame timers count ref_clk.
// - Input strobe is the inverse of the output strobe.
// - Return burst starts four 256 kHz periods after burst end.
// - Data clock is oscillator over 32; last low period stretches.
`timescale 1ns/1ps
module lsf_sequencer #(
  parameter int SILENCE_CYC = lsf_pkg::SILENCE_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Demodulator result
  input  wire logic       burst_done,
  input  wire logic [7:0] rx_voice,
  input  wire logic [1:0] rx_sig,
  input  wire logic       rx_ok,
  // Control pins
  input  wire logic       power_on_n_in,
  output logic            power_on_n_out,
  output logic            power_on_n_oe,
  input  wire logic       self_loop_n,
  input  wire logic       tone_request,
  input  wire logic       companding_select,
  // Signalling pins
  input  wire logic       sig_in_a,
  input  wire logic       sig_in_b,
  output logic            sig_out_a,
  output logic            sig_out_b,
  output logic            valid_frame_flag,
  // Codec port
  output logic            data_clk,
  output logic            out_window_strobe,
  output logic            in_window_strobe,
  output logic            voice_out,
  output logic            voice_out_oe,
  input  wire logic       voice_in,
  // Modulator request
  output logic            tx_start,
  output logic      [9:0] tx_word
);
  import lsf_pkg::*;

  localparam int SIL_W = $clog2(SILENCE_CYC + 1);
  localparam logic [SIL_W-1:0] SIL_LAST = SIL_W'(SILENCE_CYC - 1);

  typedef struct packed {
    lsf_seq_t         st;
    logic [15:0]      acc;
    logic [4:0]       half;
    logic             from_burst;
    logic [7:0]       dem_word;
    logic [7:0]       sh_out;
    logic [7:0]       sh_in;
    logic [7:0]       rx_word;
    logic [SIL_W-1:0] sil_cnt;
    logic             silent;
    logic [11:0]      frm_cnt;
    logic             frm_odd;
    logic             sig_a_l;
    logic             sig_b_l;
    logic             data_clk;
    logic             out_win;
    logic             in_win;
    logic             voice_out;
    logic             voice_oe;
    logic             sig_out_a;
    logic             sig_out_b;
    logic             vflag;
    logic             pwr_out;
    logic             pwr_oe;
    logic             tx_start;
    logic [9:0]       tx_word;
  } lsf_state_t;

  lsf_state_t r_reg;
  lsf_state_t r_next;

  logic [PIN_W-1:0] pin_s;
  logic [7:0]       tone_code;
  logic             pwr_s;
  logic             loop_act;
  logic             tone_s;
  logic             tick;
  logic             frame_tick;
  logic             start;
  logic             start_int;
  logic [16:0]      acc_sum;
  logic [4:0]       half_n;
  logic [7:0]       word;

  // Pin synchronisers
  lsf_pin_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pin_in   ({power_on_n_in, self_loop_n, tone_request, companding_select,
                sig_in_a, sig_in_b, voice_in}),
    .pin_sync (pin_s)
  );

  // Tone source advances on every frame start
  lsf_tone_gen u_tone (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .frame_pulse (start),
    .mu_law      (pin_s[PIN_MU]),
    .tone_code   (tone_code)
  );

  // Decoded control levels
  assign pwr_s     = pin_s[PIN_PWR];
  assign loop_act  = ~pin_s[PIN_LOOP] & pwr_s;
  assign tone_s    = pin_s[PIN_TONE];
  assign acc_sum   = {1'b0, r_reg.acc} + {1'b0, NCO_STEP};
  assign start_int = frame_tick & tone_s & ~burst_done;
  assign start     = burst_done | start_int;
  assign half_n    = r_reg.half + 5'h1;
  assign word      = tone_s ? tone_code : rx_voice;

  // Next-state logic
  always_comb begin
    r_next          = r_reg;
    r_next.tx_start = 1'b0;
    r_next.pwr_oe   = 1'b1;
    tick            = 1'b0;
    frame_tick      = 1'b0;
    // Oscillator-rate phase accumulator, one tick per data clock half
    if (acc_sum >= {1'b0, NCO_MOD}) begin
      r_next.acc = 16'(acc_sum - {1'b0, NCO_MOD});
      tick       = 1'b1;
    end else begin
      r_next.acc = acc_sum[15:0];
    end
    // Silence timer and weak power drive
    // Burst tested first so it wins over an expiring timer
    if (burst_done) begin
      r_next.sil_cnt = '0;
      r_next.silent  = 1'b0;
      r_next.pwr_out = 1'b1;
    end else if (r_reg.sil_cnt == SIL_LAST) begin
      r_next.silent  = 1'b1;
      r_next.vflag   = 1'b0;
      r_next.pwr_out = 1'b0;
    end else begin
      r_next.sil_cnt = r_reg.sil_cnt + SIL_W'(1);
    end
    // Free-running frame tick while silent
    if (!r_reg.silent) begin
      r_next.frm_cnt = 12'h000;
      r_next.frm_odd = 1'b0;
    end else if (r_reg.frm_cnt == FRAME_LAST) begin
      r_next.frm_cnt = 12'h000;
      r_next.frm_odd = ~r_reg.frm_odd;
      frame_tick     = 1'b1;
    end else begin
      r_next.frm_cnt = r_reg.frm_cnt + 12'h001;
    end
    // Free-running return burst on every second tick
    if (frame_tick && r_reg.frm_odd && pwr_s && !burst_done) begin
      r_next.sig_a_l  = pin_s[PIN_SA];
      r_next.sig_b_l  = pin_s[PIN_SB];
      r_next.tx_start = 1'b1;
      r_next.tx_word  = {r_reg.rx_word, pin_s[PIN_SA], pin_s[PIN_SB]};
    end
    // Sequencer
    case (r_reg.st)
      LSF_RUN: begin
        if (tick) begin
          r_next.half = half_n;
          if (r_reg.half == HALF_LAST) begin
            r_next.st       = LSF_IDLE;
            r_next.data_clk = 1'b0;
            r_next.half     = r_reg.half;
          end else begin
            r_next.data_clk = ~half_n[0];
          end
          if (r_reg.half != HALF_LAST && !half_n[0] && half_n < STROBE_END) begin
            r_next.voice_out = r_reg.sh_out[7];
            r_next.sh_out    = {r_reg.sh_out[6:0], 1'b0};
          end
          if (half_n == STROBE_END) begin
            r_next.out_win  = 1'b0;
            r_next.in_win   = 1'b1;
            r_next.voice_oe = 1'b0;
          end
          if (half_n[0] && half_n > STROBE_END) begin
            r_next.sh_in = {r_reg.sh_in[6:0], pin_s[PIN_VIN]};
            // Collected word frozen while powered down
            if (half_n == HALF_LAST && pwr_s) begin
              r_next.rx_word = {r_reg.sh_in[6:0], pin_s[PIN_VIN]};
            end
          end
          if (half_n == TX_LEAD && r_reg.from_burst && pwr_s) begin
            r_next.tx_start = 1'b1;
            r_next.tx_word  = {loop_act ? r_reg.dem_word : r_reg.rx_word,
                               r_reg.sig_a_l, r_reg.sig_b_l};
          end
        end
      end
      default: begin
        r_next.st = LSF_IDLE;
      end
    endcase
    // Frame start: burst end or internal tone frame
    // Applied after the sequencer so a new burst restarts a running frame
    if (start) begin
      r_next.st         = LSF_RUN;
      r_next.half       = 5'h00;
      r_next.acc        = 16'h0000;
      r_next.from_burst = burst_done;
      r_next.data_clk   = 1'b1;
      r_next.out_win    = 1'b1;
      r_next.in_win     = 1'b0;
      r_next.voice_oe   = 1'b1;
      r_next.voice_out  = word[7];
      r_next.sh_out     = {word[6:0], 1'b0};
      r_next.sig_a_l    = pin_s[PIN_SA];
      r_next.sig_b_l    = pin_s[PIN_SB];
      if (burst_done) begin
        r_next.dem_word  = rx_voice;
        r_next.sig_out_a = rx_sig[1];
        r_next.sig_out_b = rx_sig[0];
        r_next.vflag     = rx_ok;
      end
    end
    // Powered down: no transmission
    if (!pwr_s) begin
      r_next.tx_start = 1'b0;
    end
    // Loopback defeats the data clock
    if (loop_act) begin
      r_next.data_clk = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg        <= '0;
      r_reg.st     <= LSF_IDLE;
      r_reg.in_win <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign power_on_n_out    = r_reg.pwr_out;
  assign power_on_n_oe     = r_reg.pwr_oe;
  assign sig_out_a         = r_reg.sig_out_a;
  assign sig_out_b         = r_reg.sig_out_b;
  assign valid_frame_flag  = r_reg.vflag;
  assign data_clk          = r_reg.data_clk;
  assign out_window_strobe = r_reg.out_win;
  assign in_window_strobe  = r_reg.in_win;
  assign voice_out         = r_reg.voice_out;
  assign voice_out_oe      = r_reg.voice_oe;
  assign tx_start          = r_reg.tx_start;
  assign tx_word           = r_reg.tx_word;

  // Checks on frame behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_burst;
    burst_done && !loop_act;
  endsequence

  sequence s_frame_up;
    out_window_strobe && !in_window_strobe && data_clk && r_reg.half == 5'h00;
  endsequence

  a_strobe_inverse: assert property (in_window_strobe == !out_window_strobe)
    else $error("input strobe not inverse of output strobe");
  a_frame_start: assert property (s_burst |=> s_frame_up)
    else $error("frame did not start after burst");
  a_loop_clk_low: assert property (loop_act |=> !data_clk)
    else $error("data clock running in loopback");
  a_valid_update: assert property (burst_done |=> valid_frame_flag == $past(rx_ok))
    else $error("valid flag not taken from burst");
  a_silence_drop: assert property (
      r_reg.sil_cnt == SIL_LAST && !burst_done |=> !valid_frame_flag && !power_on_n_out)
    else $error("silence did not drop valid flag and power drive");
  a_sig_out_take: assert property (burst_done |=> {sig_out_a, sig_out_b} == $past(rx_sig))
    else $error("signalling outputs not updated");
  a_no_tx_down: assert property (!pwr_s |=> !tx_start)
    else $error("transmit while powered down");
  a_tx_lead: assert property (
      tx_start && r_reg.from_burst && !$past(frame_tick) |-> r_reg.half == TX_LEAD)
    else $error("return burst not four half periods after start");
  a_strobe_fall: assert property ($fell(out_window_strobe) |-> r_reg.half == STROBE_END)
    else $error("output strobe length wrong");
  a_voice_float: assert property (!out_window_strobe |-> !voice_out_oe)
    else $error("voice output driven outside window");
  a_clk_idle: assert property (r_reg.st == LSF_IDLE |-> !data_clk)
    else $error("data clock running while idle");

  // Return bursts, power drive and codec word
  sequence s_free_slot;
    frame_tick && r_reg.frm_odd && pwr_s && !burst_done;
  endsequence

  sequence s_free_burst;
    tx_start && tx_word[1:0] == {r_reg.sig_a_l, r_reg.sig_b_l};
  endsequence

  a_free_burst: assert property (s_free_slot |=> s_free_burst)
    else $error("free-running return burst missing");
  a_power_up: assert property (burst_done |=> power_on_n_out && power_on_n_oe)
    else $error("weak power drive not high after burst");
  a_tone_word: assert property (start && tone_s |=> voice_out == $past(tone_code[7]))
    else $error("tone word not shifted out");
  a_loop_return: assert property (
      tx_start && r_reg.from_burst && $past(loop_act) && !$past(frame_tick) && !$past(start)
      |-> tx_word[9:2] == r_reg.dem_word)
    else $error("loopback return word not demodulated voice");
  a_clk_even: assert property ($rose(data_clk) |-> !r_reg.half[0])
    else $error("data clock rose on odd half period");
endmodule

/* src/lsf_tone_gen.sv */
// PCM square-wave tone source for the loop slave sequencer.
// Assumes frame_pulse marks each frame start, one per 125 us frame.
`timescale 1ns/1ps
module lsf_tone_gen (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Frame timing and coding law
  input  wire logic       frame_pulse,
  input  wire logic       mu_law,
  // Tone word
  output logic      [7:0] tone_code
);
  import lsf_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       hi;
    logic [7:0] code;
  } lsf_tone_t;

  lsf_tone_t r_reg;
  lsf_tone_t r_next;

  // Level flips every TONE_FRAMES frames, code follows law and level
  always_comb begin
    r_next = r_reg;
    if (frame_pulse) begin
      if (r_reg.cnt == TONE_FRAMES - 4'h1) begin
        r_next.cnt = 4'h0;
        r_next.hi  = ~r_reg.hi;
      end else begin
        r_next.cnt = r_reg.cnt + 4'h1;
      end
    end
    if (mu_law) begin
      r_next.code = r_next.hi ? TONE_MU_HI : TONE_MU_LO;
    end else begin
      r_next.code = r_next.hi ? TONE_A_HI : TONE_A_LO;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{cnt: 4'h0, hi: 1'b0, code: TONE_A_LO};
    end else begin
      r_reg <= r_next;
    end
  end

  assign tone_code = r_reg.code;
endmodule

/* verif/lsf_master_model.sv */
// Switch-side master model: hands over demodulated bursts, counts replies.
// Assumes the bench asks for each burst with a one-cycle send pulse.
`timescale 1ns/1ps
module lsf_master_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Bench request
  input  wire logic       send,
  input  wire logic [7:0] s_voice,
  input  wire logic [1:0] s_sig,
  input  wire logic       s_ok,
  // Demodulator result
  output logic            burst_done,
  output logic      [7:0] rx_voice,
  output logic      [1:0] rx_sig,
  output logic            rx_ok,
  // Return bursts
  input  wire logic       tx_start,
  output int              ret_cnt
);
  // Result valid only with the done pulse; stale data is scrambled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_done <= 1'b0;
      rx_voice   <= 8'h00;
      rx_sig     <= 2'h0;
      rx_ok      <= 1'b0;
      ret_cnt    <= 0;
    end else begin
      burst_done <= send;
      rx_voice   <= send ? s_voice : ~rx_voice;
      rx_sig     <= send ? s_sig : ~rx_sig;
      rx_ok      <= send ? s_ok : ~rx_ok;
      ret_cnt    <= ret_cnt + int'(tx_start);
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the loop slave frame sequencer.
// Assumes lsf_master_model in place of the switch-side master.
`timescale 1ns/1ps
module tb_top;
  import lsf_pkg::*;
  localparam int SIL   = 4000;
  localparam int LIMIT = 60000;
  // Stimulus
  logic       ref_clk = 1'b0, arst_n = 1'b0, send = 1'b0, s_ok = 1'b0;
  logic [7:0] s_voice = 8'h00;
  logic [1:0] s_sig = 2'h0;
  logic       pd_ext_en = 1'b0, pd_ext_val = 1'b1, self_loop_n = 1'b1;
  logic       tone_request = 1'b0, companding_select = 1'b1;
  logic       sig_in_a = 1'b0, sig_in_b = 1'b0, voice_in = 1'b0;
  // Design and model outputs
  logic       burst_done, rx_ok, pw_out, pw_oe, sig_out_a, sig_out_b;
  logic       valid_frame_flag, data_clk, out_window_strobe, in_window_strobe;
  logic       voice_out, voice_out_oe, tx_start;
  logic [7:0] rx_voice, m_vo;
  logic [1:0] rx_sig;
  logic [9:0] tx_word, m_txw;
  int         ret_cnt, m_rises, m_slen, m_txn, m_txd, m_per, m_inv, k;
  int         error_cnt = 0, total_checks = 0, cyc = 0;
  wire        pd_pin;
  // Power pin: external driver beats the weak one, pull-up otherwise
  assign pd_pin = pd_ext_en ? pd_ext_val : (pw_oe ? pw_out : 1'b1);

  lsf_master_model u_lsf_master_model (.ref_clk, .arst_n, .send, .s_voice, .s_sig,
    .s_ok, .burst_done, .rx_voice, .rx_sig, .rx_ok, .tx_start, .ret_cnt);
  lsf_sequencer #(.SILENCE_CYC(SIL)) u_lsf_sequencer (.ref_clk, .arst_n, .burst_done,
    .rx_voice, .rx_sig, .rx_ok, .power_on_n_in(pd_pin), .power_on_n_out(pw_out),
    .power_on_n_oe(pw_oe), .self_loop_n, .tone_request, .companding_select, .sig_in_a,
    .sig_in_b, .sig_out_a, .sig_out_b, .valid_frame_flag, .data_clk, .out_window_strobe,
    .in_window_strobe, .voice_out, .voice_out_oe, .voice_in, .tx_start, .tx_word);

  // Clock
  initial forever #20 ref_clk = ~ref_clk;

  // Compare tasks
  task automatic chk1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkw(input string what, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkr(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wait_tx();
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (tx_start !== 1'b1 && k < 7000);
  endtask

  // One master burst, then watch the frame and act as the codec
  task automatic frame(input logic [7:0] v, input logic [1:0] s, input logic ok,
                       input logic [7:0] cw);
    int  n0, t0, r1, vk, ck;
    logic pc, ps, drv, nb;
    n0 = ret_cnt; t0 = 0; r1 = 0; vk = 0; ck = 0; pc = 1'b0; ps = 1'b0; nb = 1'b0;
    m_rises = 0; m_slen = 0; m_inv = 0; m_txd = -1; m_per = 0; m_vo = 8'h00;
    @(posedge ref_clk);
    send <= 1'b1; s_voice <= v; s_sig <= s; s_ok <= ok;
    @(posedge ref_clk);
    send <= 1'b0;
    for (int i = 0; i < 3200; i++) begin
      @(negedge ref_clk);
      if (in_window_strobe !== ~out_window_strobe || voice_out_oe !== out_window_strobe)
        m_inv++;
      if (out_window_strobe === 1'b1) m_slen++;
      if (out_window_strobe === 1'b1 && !ps) t0 = i;
      if (tx_start === 1'b1) begin
        m_txd = i - t0;
        m_txw = tx_word;
      end
      drv = (data_clk === 1'b1 && !pc);
      if (drv) begin
        m_rises++;
        if (m_rises == 2) m_per = i - r1;
        r1 = i;
        if (out_window_strobe === 1'b1 && vk < 8) begin
          m_vo[7-vk] = voice_out;
          vk++;
        end
        nb = (in_window_strobe === 1'b1 && ck < 8);
      end
      pc = data_clk;
      ps = out_window_strobe;
      @(posedge ref_clk);
      // Codec bit ahead of each falling edge; idle line keeps toggling
      if (drv && nb) begin
        voice_in <= cw[7-ck];
        ck++;
      end else if (drv) voice_in <= ~voice_in;
    end
    m_txn = ret_cnt - n0;
  endtask

  // Scenarios
  task automatic t_normal();
    @(posedge ref_clk);
    sig_in_a <= 1'b1;
    sig_in_b <= 1'b0;
    wait_cyc(10);
    frame(8'hA5, 2'b10, 1'b1, 8'h3C);
    chkw("voice out", 10'(8'hA5), 10'(m_vo));
    chkr("clk rises", 16, 16, m_rises);
    chkr("clk period", 194, 197, m_per);
    chkr("strobe high", 1555, 1570, m_slen);
    chkr("window pins", 0, 0, m_inv);
    chkr("returns", 1, 1, m_txn);
    chkr("tx delay", 385, 396, m_txd);
    chkw("tx sig", 10'(2'b10), 10'(m_txw[1:0]));
    chk1("sig a", 1'b1, sig_out_a);
    chk1("sig b", 1'b0, sig_out_b);
    chk1("valid", 1'b1, valid_frame_flag);
    chk1("power drive", 1'b1, pw_out);
    chk1("power oe", 1'b1, pw_oe);
    frame(8'hC3, 2'b01, 1'b1, 8'h81);
    chkw("tx voice", 10'(8'h3C), 10'(m_txw[9:2]));
    chk1("sig a", 1'b0, sig_out_a);
    chk1("sig b", 1'b1, sig_out_b);
  endtask
  task automatic t_bad_loop();
    frame(8'h11, 2'b11, 1'b0, 8'h42);
    chk1("valid", 1'b0, valid_frame_flag);
    chk1("sig a", 1'b1, sig_out_a);
    @(posedge ref_clk);
    self_loop_n <= 1'b0;
    wait_cyc(10);
    frame(8'h5A, 2'b00, 1'b1, 8'h99);
    chkr("loop clk rises", 0, 0, m_rises);
    chkw("loop voice", 10'(8'h5A), 10'(m_txw[9:2]));
    @(posedge ref_clk);
    self_loop_n <= 1'b1;
  endtask
  task automatic t_tone();
    @(posedge ref_clk);
    tone_request <= 1'b1;
    wait_cyc(10);
    frame(8'h00, 2'b00, 1'b1, 8'hE7);
    chk1("mu tone", 1'b1, m_vo === TONE_MU_HI || m_vo === TONE_MU_LO);
    @(posedge ref_clk);
    companding_select <= 1'b0;
    wait_cyc(10);
    frame(8'h00, 2'b00, 1'b1, 8'h18);
    chk1("a tone", 1'b1, m_vo === TONE_A_HI || m_vo === TONE_A_LO);
    @(posedge ref_clk);
    tone_request <= 1'b0;
  endtask
  task automatic t_pdown_silence();
    @(posedge ref_clk);
    pd_ext_en <= 1'b1;
    pd_ext_val <= 1'b0;
    wait_cyc(10);
    frame(8'h24, 2'b01, 1'b1, 8'h6B);
    chkr("down returns", 0, 0, m_txn);
    chkr("down strobe", 1555, 1570, m_slen);
    chkw("down voice", 10'(8'h24), 10'(m_vo));
    chk1("valid kept", 1'b1, valid_frame_flag);
    pd_ext_en <= 1'b0;
    wait_cyc(1000);
    chk1("valid silent", 1'b0, valid_frame_flag);
    chk1("power drive", 1'b0, pw_out);
  endtask
  task automatic t_free();
    @(posedge ref_clk);
    pd_ext_en <= 1'b1;
    pd_ext_val <= 1'b1;
    sig_in_a <= 1'b1;
    sig_in_b <= 1'b1;
    wait_tx();
    chkr("free start", 1, 6999, k);
    wait_tx();
    chkr("free gap", 6249, 6251, k);
    chkw("free sig", 10'(2'b11), 10'(tx_word[1:0]));
    chkw("free voice", 10'(8'h18), 10'(tx_word[9:2]));
    @(posedge ref_clk);
    tone_request <= 1'b1;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (out_window_strobe !== 1'b1 && k < 3300);
    chkr("tone frame", 1, 3299, k);
    chk1("in strobe", 1'b0, in_window_strobe);
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    chk1("rst out strobe", 1'b0, out_window_strobe);
    chk1("rst in strobe", 1'b1, in_window_strobe);
    chk1("rst tx", 1'b0, tx_start);
    wait_cyc(2);
    arst_n <= 1'b1;
    wait_cyc(10);
    t_normal();
    t_bad_loop();
    t_tone();
    t_pdown_silence();
    t_free();
    give_verdict();
  end
endmodule
